// ==== hw/irq_enable_pkg.sv ====
package irq_enable_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_ENABLE_LO = 8'h17;
  localparam logic [7:0]  IDX_ENABLE_HI = 8'h11;
  localparam logic [7:0]  IDX_BANK_SEL  = 8'h0f;
  localparam logic [7:0]  IDX_PENDING   = 8'h20;

  // Bank in which each enable register is visible
  localparam logic [3:0]  BANK_ENABLE_LO = 4'h1;
  localparam logic [3:0]  BANK_ENABLE_HI = 4'h4;

  // Field positions in the low enable register
  localparam int          SERIAL1_RX_FULL_IRQ_ENABLE  = 0;
  localparam int          SERIAL1_TX_EMPTY_IRQ_ENABLE = 1;
  localparam int          CAPTURE1_IRQ_ENABLE         = 2;
  localparam int          CAPTURE2_IRQ_ENABLE         = 3;
  localparam int          TIMER1_IRQ_ENABLE           = 4;

  // Field positions in the high enable register
  localparam int          SERIAL2_RX_FULL_IRQ_ENABLE  = 0;
  localparam int          SERIAL2_TX_EMPTY_IRQ_ENABLE = 1;
  localparam int          CAPTURE3_IRQ_ENABLE         = 2;
  localparam int          CAPTURE4_IRQ_ENABLE         = 3;
  localparam int          HI_UNUSED_BIT               = 4;
  localparam int          ADC_DONE_IRQ_ENABLE         = 5;
  localparam int          BUS_COLLISION_IRQ_ENABLE    = 6;
  localparam int          SYNC_SERIAL_IRQ_ENABLE      = 7;

  // Implemented bits and reset values
  localparam logic [7:0]  ENABLE_HI_MASK  = 8'hef;
  localparam logic [4:0]  ENABLE_LO_RESET = 5'h00;
  localparam logic [7:0]  ENABLE_HI_RESET = 8'h00;
  localparam logic [3:0]  BANK_SEL_RESET  = 4'h0;

  // Peripheral flag inputs, grouped as the two enable registers
  typedef struct packed {
    logic [7:0] hi;
    logic [4:0] lo;
  } periph_flags_t;

  // Captured AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] idx;
  } ahb_req_t;

endpackage

// ==== hw/peripheral_irq_enable_regs.sv ====
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
// Contract
// R1 - bit 4 low register gates timer1 interrupt
// R2 - bit 3 low register gates capture2 interrupt
// R3 - bit 2 low register gates capture1 interrupt
// R4 - bit 1 low gates serial1 transmit empty
// R5 - bit 0 low gates serial1 receive full
// R6 - high register at 0x11, bank 4 only
// R7 - bit 7 high gates sync serial interrupt
// R8 - bit 6 high gates bus collision interrupt
// R9 - bit 5 high gates converter done interrupt
// R10 - bit 4 high reads zero, ignores writes
// R11 - bit 3 high gates capture4 interrupt
// R12 - bit 2 high gates capture3 interrupt
// R13 - bit 1 high gates serial2 transmit empty
// R14 - bit 0 high gates serial2 receive full
// R15 - reset clears high register, then read/write
// R16 - low register at 0x17, bank 1 only
// R17 - enables mask requests, never block flags
// R18 - request when any flag and enable set
module peripheral_irq_enable_regs (
  // Clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Peripheral flags and combined request
  input  wire irq_enable_pkg::periph_flags_t periph_flags,
  output logic                               periph_irq
);

  irq_enable_pkg::ahb_req_t req;            // Pending data phase
  logic [4:0]               enable_lo;      // Low enable register
  logic [7:0]               enable_hi;      // High enable register
  logic [3:0]               bank_sel;       // Data memory bank select
  logic [4:0]               next_enable_lo; // Values after this cycle's write
  logic [7:0]               next_enable_hi;
  logic [3:0]               next_bank_sel;
  logic [7:0]               pending_lo;     // Flags passed by enables
  logic [7:0]               pending_hi;
  logic                     addr_take;      // Address phase taken now
  logic [7:0]               addr_idx;       // Word index of that address
  logic                     wr_now;         // Data phase of a write now
  logic [31:0]              next_rdata;

  // Only word transfers are expected; hsize is accepted without check
  assign addr_take = hsel && hready && htrans[1];
  assign addr_idx  = haddr[9:2];
  assign wr_now    = req.valid && req.write;

  // Masking only: flags come straight from peripherals, untouched
  assign pending_lo = {3'h0, periph_flags.lo & enable_lo}; // R17 R1 R2 R3 R4 R5
  assign pending_hi = periph_flags.hi & enable_hi;         // R17 R7 R8 R9 R11 R12 R13 R14

  // Capture the address phase for the following data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      req <= '0;
    else if (hready)
      req <= '{valid: addr_take, write: hwrite, idx: addr_idx};
  end

  // Next register values; a write in its data phase takes effect now
  always_comb
  begin
    next_enable_lo = enable_lo;
    next_enable_hi = enable_hi;
    next_bank_sel  = bank_sel;
    if (wr_now)
    begin
      // Bank select is always visible
      if (req.idx == irq_enable_pkg::IDX_BANK_SEL)
        next_bank_sel = hwdata[3:0];
      // Low register answers only in its bank
      if (req.idx == irq_enable_pkg::IDX_ENABLE_LO &&
          bank_sel == irq_enable_pkg::BANK_ENABLE_LO)        // R16
        next_enable_lo = hwdata[4:0];                         // R1 R2 R3 R4 R5
      // High register answers only in its bank
      if (req.idx == irq_enable_pkg::IDX_ENABLE_HI &&
          bank_sel == irq_enable_pkg::BANK_ENABLE_HI)        // R6
        next_enable_hi = hwdata[7:0] & irq_enable_pkg::ENABLE_HI_MASK; // R10
    end
  end

  // Enable registers; power-on reset clears every bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable_lo <= irq_enable_pkg::ENABLE_LO_RESET;
      enable_hi <= irq_enable_pkg::ENABLE_HI_RESET; // R15
    end
    else
    begin
      enable_lo <= next_enable_lo;
      enable_hi <= next_enable_hi;                  // R15
    end
  end

  // Bank select register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bank_sel <= irq_enable_pkg::BANK_SEL_RESET;
    else
      bank_sel <= next_bank_sel;
  end

  // Read mux uses next values so a write just before a read is seen
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (addr_take && !hwrite)
    begin
      unique case (addr_idx)
        irq_enable_pkg::IDX_ENABLE_LO:
          if (next_bank_sel == irq_enable_pkg::BANK_ENABLE_LO) // R16
            next_rdata = {27'h0, next_enable_lo};
        irq_enable_pkg::IDX_ENABLE_HI:
          if (next_bank_sel == irq_enable_pkg::BANK_ENABLE_HI) // R6
            next_rdata = {24'h0, next_enable_hi};
        irq_enable_pkg::IDX_BANK_SEL:
          next_rdata = {28'h0, next_bank_sel};
        irq_enable_pkg::IDX_PENDING:
          next_rdata = {16'h0, pending_hi, pending_lo};
        // Unmapped addresses read zero with an OKAY response
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data register, loaded at the address phase edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready)
      hrdata <= next_rdata;
  end

  // Zero wait states and always OKAY, so both stay constant
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Combined request, one cycle behind the flags, checked every cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      periph_irq <= 1'b0;
    else
      periph_irq <= |{pending_hi, pending_lo}; // R18
  end

  // Per-source gating, each enable tied to the request one cycle later
  property p_timer1;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.lo[4] && enable_lo[4]) |=> periph_irq;
  endproperty
  a_timer1: assert property (p_timer1) else $error("timer1 not requested"); // R1

  property p_capture2;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.lo[3] && enable_lo[3]) |=> periph_irq;
  endproperty
  a_capture2: assert property (p_capture2) else $error("capture2 not requested"); // R2

  property p_capture1;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.lo[2] && enable_lo[2]) |=> periph_irq;
  endproperty
  a_capture1: assert property (p_capture1) else $error("capture1 not requested"); // R3

  property p_ser1_tx;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.lo[1] && enable_lo[1]) |=> periph_irq;
  endproperty
  a_ser1_tx: assert property (p_ser1_tx) else $error("serial1 tx not requested"); // R4

  property p_ser1_rx;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.lo[0] && enable_lo[0]) |=> periph_irq;
  endproperty
  a_ser1_rx: assert property (p_ser1_rx) else $error("serial1 rx not requested"); // R5

  property p_hi_bank;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && bank_sel != irq_enable_pkg::BANK_ENABLE_HI) |=> $stable(enable_hi);
  endproperty
  a_hi_bank: assert property (p_hi_bank) else $error("high written outside bank"); // R6

  property p_sync_ser;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.hi[7] && enable_hi[7]) |=> periph_irq;
  endproperty
  a_sync_ser: assert property (p_sync_ser) else $error("sync serial not requested"); // R7

  property p_bus_coll;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.hi[6] && enable_hi[6]) |=> periph_irq;
  endproperty
  a_bus_coll: assert property (p_bus_coll) else $error("collision not requested"); // R8

  property p_adc;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.hi[5] && enable_hi[5]) |=> periph_irq;
  endproperty
  a_adc: assert property (p_adc) else $error("converter not requested"); // R9

  // A flag on the unimplemented position must never raise the request alone
  property p_unused;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.hi[irq_enable_pkg::HI_UNUSED_BIT] && !(|pending_lo) &&
     !(|(pending_hi & irq_enable_pkg::ENABLE_HI_MASK))) |=> !periph_irq;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit acted"); // R10

  // The unimplemented enable bit never holds a one
  property p_unused_bit;
    @(posedge hclk) disable iff (!hresetn)
    !enable_hi[irq_enable_pkg::HI_UNUSED_BIT];
  endproperty
  a_unused_bit: assert property (p_unused_bit) else $error("unused bit set"); // R10

  property p_capture4;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.hi[3] && enable_hi[3]) |=> periph_irq;
  endproperty
  a_capture4: assert property (p_capture4) else $error("capture4 not requested"); // R11

  property p_capture3;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.hi[2] && enable_hi[2]) |=> periph_irq;
  endproperty
  a_capture3: assert property (p_capture3) else $error("capture3 not requested"); // R12

  property p_ser2_tx;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.hi[1] && enable_hi[1]) |=> periph_irq;
  endproperty
  a_ser2_tx: assert property (p_ser2_tx) else $error("serial2 tx not requested"); // R13

  property p_ser2_rx;
    @(posedge hclk) disable iff (!hresetn)
    (periph_flags.hi[0] && enable_hi[0]) |=> periph_irq;
  endproperty
  a_ser2_rx: assert property (p_ser2_rx) else $error("serial2 rx not requested"); // R14

  property p_reset_clear;
    @(posedge hclk) disable iff (!hresetn)
    $past(!hresetn) |-> (enable_hi == 8'h00 && enable_lo == 5'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not cleared"); // R15

  property p_lo_bank;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && req.idx == irq_enable_pkg::IDX_ENABLE_LO &&
     bank_sel == irq_enable_pkg::BANK_ENABLE_LO) |=> (enable_lo == $past(hwdata[4:0]));
  endproperty
  a_lo_bank: assert property (p_lo_bank) else $error("low write lost"); // R16

  property p_mask_only;
    @(posedge hclk) disable iff (!hresetn)
    !(|{pending_hi, pending_lo}) |=> !periph_irq;
  endproperty
  a_mask_only: assert property (p_mask_only) else $error("request without enable"); // R17

  property p_any;
    @(posedge hclk) disable iff (!hresetn)
    (|{pending_hi, pending_lo}) |=> periph_irq;
  endproperty
  a_any: assert property (p_any) else $error("request missing"); // R18

  // Main scenarios
  c_lo_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_now && req.idx == irq_enable_pkg::IDX_ENABLE_LO &&
    bank_sel == irq_enable_pkg::BANK_ENABLE_LO);
  c_hi_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_now && req.idx == irq_enable_pkg::IDX_ENABLE_HI &&
    bank_sel == irq_enable_pkg::BANK_ENABLE_HI);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(periph_irq));
  c_masked: cover property (@(posedge hclk) disable iff (!hresetn)
    (|periph_flags.hi) && !(|pending_hi));

endmodule

// ==== testbench/peripheral_irq_enable_regs_test.sv ====
`timescale 1ns/10ps
module peripheral_irq_enable_regs_test;
  // Bus master and flag stimulus, all driven by the bench
  logic                          hclk         = 1'b0;
  logic                          hresetn      = 1'b0;
  logic                          hsel         = 1'b0;
  logic [31:0]                   haddr        = 32'h0;
  logic [1:0]                    htrans       = 2'h0;
  logic                          hwrite       = 1'b0;
  logic [2:0]                    hsize        = 3'h2;
  logic [31:0]                   hwdata       = 32'h0;
  irq_enable_pkg::periph_flags_t periph_flags = '0;
  // Slave answers
  logic [31:0]                   hrdata;
  logic                          hreadyout;
  logic                          hresp;
  logic                          periph_irq;
  // Bookkeeping
  int                            n_fail       = 0;
  int                            num_checks   = 0;
  logic [31:0]                   rd;          // Data taken by the last transfer
  logic [12:0]                   en;          // Enables under test, hi then lo
  int                            i;

  // 40 MHz core clock
  always #12.5 hclk = ~hclk;

  // Single slave, so its own ready is the bus ready
  peripheral_irq_enable_regs dut (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .periph_flags (periph_flags),
    .periph_irq   (periph_irq)
  );

  // Counts and verdict, the one place the run ends
  task print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare with case equality so an unknown never matches
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // Bounded wait for ready at a rising edge; a stuck slave ends the run
  task wait_ready;
    int k;
    for (k = 0; k < 16; k++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    $display("BAD hready expected 1 seen stuck");
    n_fail++;
    print_verdict();
  endtask

  // One single word transfer; entered just after a rising edge
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    // Address taken: bus goes idle for the data phase, no next address overlaps it
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Select a bank, then write or read a banked register
  task wreg(input logic [3:0] bank, input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, irq_enable_pkg::IDX_BANK_SEL, {28'h0, bank});
    bus(1'b1, idx, d);
  endtask

  task rreg(input logic [3:0] bank, input logic [7:0] idx);
    bus(1'b1, irq_enable_pkg::IDX_BANK_SEL, {28'h0, bank});
    bus(1'b0, idx, 32'h0);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Power-on values
    rreg(4'h4, irq_enable_pkg::IDX_ENABLE_HI);
    check("enable_hi after reset", 32'h0, rd);
    rreg(4'h1, irq_enable_pkg::IDX_ENABLE_LO);
    check("enable_lo after reset", 32'h0, rd);
    check("irq after reset", 32'h0, {31'h0, periph_irq});
    // Low register is seen in bank 1 only; upper bits absent
    wreg(4'h1, irq_enable_pkg::IDX_ENABLE_LO, 32'hffffffff);
    rreg(4'h1, irq_enable_pkg::IDX_ENABLE_LO);
    check("enable_lo bank 1", 32'h1f, rd);
    rreg(4'h0, irq_enable_pkg::IDX_ENABLE_LO);
    check("enable_lo bank 0", 32'h0, rd);
    rreg(4'h4, irq_enable_pkg::IDX_ENABLE_LO);
    check("enable_lo bank 4", 32'h0, rd);
    // High register in bank 4 only; bit 4 never sticks
    wreg(4'h4, irq_enable_pkg::IDX_ENABLE_HI, 32'hffffffff);
    rreg(4'h4, irq_enable_pkg::IDX_ENABLE_HI);
    check("enable_hi all ones", 32'hef, rd);
    rreg(4'h1, irq_enable_pkg::IDX_ENABLE_HI);
    check("enable_hi bank 1", 32'h0, rd);
    wreg(4'h1, irq_enable_pkg::IDX_ENABLE_HI, 32'h0);
    rreg(4'h4, irq_enable_pkg::IDX_ENABLE_HI);
    check("enable_hi wrong bank write", 32'hef, rd);
    wreg(4'h4, irq_enable_pkg::IDX_ENABLE_HI, 32'h10);
    rreg(4'h4, irq_enable_pkg::IDX_ENABLE_HI);
    check("enable_hi unused bit", 32'h0, rd);
    // Unmapped place: writes vanish, reads give zero
    wreg(4'h4, 8'h3f, 32'hffffffff);
    rreg(4'h4, 8'h3f);
    check("unmapped read", 32'h0, rd);
    // Each enable alone: its own flag passes except at bit 9 (high bit 4), every other flag is masked
    for (i = 0; i < 13; i++)
    begin
      en = 13'h1 << i;
      wreg(4'h1, irq_enable_pkg::IDX_ENABLE_LO, {27'h0, en[4:0]});
      wreg(4'h4, irq_enable_pkg::IDX_ENABLE_HI, {24'h0, en[12:5]});
      periph_flags <= irq_enable_pkg::periph_flags_t'(~en);
      repeat (2) @(posedge hclk);
      check("irq other flags", 32'h0, {31'h0, periph_irq});
      periph_flags <= irq_enable_pkg::periph_flags_t'(en);
      repeat (2) @(posedge hclk);
      // Bit 4 of the high register has no enable, so its flag stays masked
      check("irq own flag", {31'h0, i != 9}, {31'h0, periph_irq});
      rreg(4'h0, irq_enable_pkg::IDX_PENDING);
      check("pending", {16'h0, en[12:5] & irq_enable_pkg::ENABLE_HI_MASK, 3'h0, en[4:0]},
            rd);
    end
    // Reset in mid-run clears the enables that the loop left set
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("irq in reset", 32'h0, {31'h0, periph_irq});
    hresetn <= 1'b1;
    @(posedge hclk);
    rreg(4'h4, irq_enable_pkg::IDX_ENABLE_HI);
    check("enable_hi after mid reset", 32'h0, rd);
    rreg(4'h1, irq_enable_pkg::IDX_ENABLE_LO);
    check("enable_lo after mid reset", 32'h0, rd);
    check("irq after mid reset", 32'h0, {31'h0, periph_irq});
    print_verdict();
  end
endmodule
